// >>> logic/pirq_apb_port.sv
// APB slave front end: decode, write strobe, registered read data
`timescale 1ns/10ps
module pirq_apb_port (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic      [31:0]          prdata,
    output logic                      pslverr,
    output pirq_pkg::pirq_wr_s        wr,
    output pirq_pkg::pirq_idx_e       rd_idx,
    input  wire logic [31:0]          rd_data
);

    logic               setup_phase;
    logic               access_phase;
    pirq_pkg::pirq_idx_e hit_idx;
    logic               hit_none;
    logic [31:0]        next_prdata;
    logic               next_pslverr;

    // Zero wait state slave
    assign pready       = 1'b1;
    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable & pready;
    assign hit_idx      = pirq_pkg::pirq_decode(paddr);
    assign hit_none     = (hit_idx == pirq_pkg::IDX_NONE);
    assign rd_idx       = hit_idx;

    // Write takes effect at the access edge only
    assign wr.valid     = access_phase & pwrite & ~hit_none;
    assign wr.idx       = hit_idx;
    assign wr.data      = pwdata[7:0];

    // Read data and error sampled at the setup edge
    assign next_prdata  = setup_phase ? ((pwrite | hit_none) ? 32'h0000_0000 : rd_data) : prdata;
    assign next_pslverr = setup_phase ? hit_none : pslverr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

endmodule // pirq_apb_port

// >>> logic/pirq_pkg.sv
// Shared constants, types and decoding for the peripheral interrupt priority block
package pirq_pkg;

    localparam int          ADDR_W            = 12;
    localparam int          NUM_SRC           = 14;

    localparam logic [11:0] OFF_PRIO_A        = 12'h000;
    localparam logic [11:0] OFF_PRIO_B        = 12'h004;
    localparam logic [11:0] OFF_CTRL          = 12'h008;
    localparam logic [11:0] OFF_LEVEL_MAP     = 12'h00C;
    localparam logic [11:0] OFF_PENDING       = 12'h010;

    localparam logic [7:0]  PRIO_A_MASK_FULL  = 8'h00FF;
    localparam logic [7:0]  PRIO_A_MASK_SMALL = 8'h007F;
    localparam logic [7:0]  PRIO_B_MASK       = 8'h00CF;
    localparam logic [7:0]  PRIO_RESET        = 8'h00FF;
    localparam logic [7:0]  CTRL_RESET        = 8'h0000;

    typedef enum logic [2:0] {
        IDX_NONE  = 3'h0,
        IDX_PRIO_A = 3'h1,
        IDX_PRIO_B = 3'h2,
        IDX_CTRL  = 3'h3,
        IDX_MAP   = 3'h4,
        IDX_PEND  = 3'h5
    } pirq_idx_e;

    typedef struct packed {
        logic parallel_port_prio;
        logic adc_done_prio;
        logic serial_rx_prio;
        logic serial_tx_prio;
        logic sync_serial_prio;
        logic capcmp1_prio;
        logic timer2_match_prio;
        logic timer1_ovf_prio;
    } pirq_prio_a_s;

    typedef struct packed {
        logic       osc_fail_prio;
        logic       comparator_prio;
        logic [1:0] unused;
        logic       bus_collision_prio;
        logic       volt_detect_prio;
        logic       timer3_ovf_prio;
        logic       capcmp2_prio;
    } pirq_prio_b_s;

    typedef struct packed {
        logic       priority_levels_enable;
        logic [6:0] unused;
    } pirq_ctrl_s;

    typedef struct packed {
        logic      valid;
        pirq_idx_e idx;
        logic [7:0] data;
    } pirq_wr_s;

    // Address to register index
    function automatic pirq_idx_e pirq_decode(input logic [11:0] addr);
        case (addr)
            OFF_PRIO_A:    pirq_decode = IDX_PRIO_A;
            OFF_PRIO_B:    pirq_decode = IDX_PRIO_B;
            OFF_CTRL:      pirq_decode = IDX_CTRL;
            OFF_LEVEL_MAP: pirq_decode = IDX_MAP;
            OFF_PENDING:   pirq_decode = IDX_PEND;
            default:       pirq_decode = IDX_NONE;
        endcase
    endfunction

    // Source order: reg a bits 7..0 in [7:0], reg b implemented bits in [13:8]
    function automatic logic [13:0] pirq_src_vec(input logic [7:0] a, input logic [7:0] b);
        pirq_src_vec = {b[7], b[6], b[3:0], a};
    endfunction

endpackage

// >>> logic/pirq_prio_regs.sv
// Peripheral interrupt priority registers with APB access and level routing
`timescale 1ns/10ps

module pirq_prio_regs #(
    parameter bit REDUCED_PINS = 1'b0
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic      [31:0]          prdata,
    output logic                      pslverr,
    input  wire logic [13:0]          src_pending,
    output logic      [13:0]          src_high_level,
    output logic                      levels_enable,
    output logic                      irq_high_pend,
    output logic                      irq_low_pend
);

    localparam logic [7:0] PRIO_A_MASK = REDUCED_PINS ? pirq_pkg::PRIO_A_MASK_SMALL
                                                      : pirq_pkg::PRIO_A_MASK_FULL;

    pirq_pkg::pirq_wr_s   wr;
    pirq_pkg::pirq_idx_e  rd_idx;
    logic [31:0]          rd_data;

    pirq_pkg::pirq_prio_a_s prio_a;
    pirq_pkg::pirq_prio_b_s prio_b;
    pirq_pkg::pirq_ctrl_s   ctrl;

    logic [7:0]           next_prio_a;
    logic [7:0]           next_prio_b;
    logic [7:0]           next_ctrl;
    logic [13:0]          raw_prio;
    logic [13:0]          eff_high;
    logic [13:0]          route_high;
    logic [13:0]          route_low;
    logic [13:0]          next_src_high_level;
    logic [13:0]          pend_high_vec;
    logic [13:0]          pend_low_vec;
    logic                 wr_a;
    logic                 wr_b;
    logic                 wr_ctrl;

    pirq_apb_port u_port (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pready  (pready),
        .prdata  (prdata),
        .pslverr (pslverr),
        .wr      (wr),
        .rd_idx  (rd_idx),
        .rd_data (rd_data)
    );

    // Write strobes per register
    assign wr_a    = wr.valid & (wr.idx == pirq_pkg::IDX_PRIO_A);
    assign wr_b    = wr.valid & (wr.idx == pirq_pkg::IDX_PRIO_B);
    assign wr_ctrl = wr.valid & (wr.idx == pirq_pkg::IDX_CTRL);

    // Unimplemented bits masked off on write
    assign next_prio_a = wr_a ? (wr.data & PRIO_A_MASK) : prio_a;
    assign next_prio_b = wr_b ? (wr.data & pirq_pkg::PRIO_B_MASK) : prio_b;
    assign next_ctrl   = wr_ctrl ? {wr.data[7], 7'h00} : ctrl;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_a <= pirq_pkg::PRIO_RESET & PRIO_A_MASK;
            prio_b <= pirq_pkg::PRIO_RESET & pirq_pkg::PRIO_B_MASK;
            ctrl   <= pirq_pkg::CTRL_RESET;
        end else begin
            prio_a <= next_prio_a;
            prio_b <= next_prio_b;
            ctrl   <= next_ctrl;
        end
    end

    // Per-source level map
    assign raw_prio   = pirq_pkg::pirq_src_vec(prio_a, prio_b);
    // Single-level mode sends every source to the one vector
    assign eff_high   = ctrl.priority_levels_enable ? raw_prio : 14'h3FFF;
    // Per-source steering to one of the two levels
    for (genvar s = 0; s < pirq_pkg::NUM_SRC; s++) begin : g_route
        assign route_high[s] = src_pending[s] & eff_high[s];
        assign route_low[s]  = src_pending[s] & ~eff_high[s];
    end
    assign next_src_high_level = eff_high;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_high_level <= 14'h3FFF;
            pend_high_vec  <= 14'h0000;
            pend_low_vec   <= 14'h0000;
            levels_enable  <= 1'b0;
            irq_high_pend  <= 1'b0;
            irq_low_pend   <= 1'b0;
        end else begin
            src_high_level <= next_src_high_level;
            pend_high_vec  <= route_high;
            pend_low_vec   <= route_low;
            levels_enable  <= ctrl.priority_levels_enable;
            irq_high_pend  <= |route_high;
            irq_low_pend   <= |route_low;
        end
    end

    // Read mux
    always_comb begin
        case (rd_idx)
            pirq_pkg::IDX_PRIO_A: rd_data = {24'h00_0000, prio_a};
            pirq_pkg::IDX_PRIO_B: rd_data = {24'h00_0000, prio_b};
            pirq_pkg::IDX_CTRL:   rd_data = {24'h00_0000, ctrl};
            pirq_pkg::IDX_MAP:    rd_data = {18'h0_0000, src_high_level};
            pirq_pkg::IDX_PEND:   rd_data = {2'b00, pend_low_vec, 2'b00, pend_high_vec};
            default:              rd_data = 32'h0000_0000;
        endcase
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_write_a;
        psel && penable && pwrite && paddr == pirq_pkg::OFF_PRIO_A;
    endsequence

    sequence s_write_b;
        psel && penable && pwrite && paddr == pirq_pkg::OFF_PRIO_B;
    endsequence

    sequence s_read_setup(logic [11:0] off);
        psel && !penable && !pwrite && paddr == off;
    endsequence

    chk_write_a_store: assert property (
        s_write_a |=> prio_a == ($past(pwdata[7:0]) & PRIO_A_MASK))
        else $error("priority_reg_a did not store masked write data");

    chk_write_b_gaps: assert property (
        s_write_b |=> prio_b == ($past(pwdata[7:0]) & 8'h00CF) && prio_b[5:4] == 2'b00)
        else $error("priority_reg_b bits 5-4 not zero after write");

    chk_reduced_bit: assert property (
        REDUCED_PINS |-> prio_a.parallel_port_prio == 1'b0)
        else $error("reduced variant holds a value in reg a bit 7");

    chk_levels_off: assert property (
        !ctrl.priority_levels_enable |=> src_high_level == 14'h3FFF && !irq_low_pend)
        else $error("priority bits applied while levels disabled");

    chk_levels_route: assert property (
        ctrl.priority_levels_enable |=> src_high_level == $past(raw_prio))
        else $error("level map does not follow priority bits");

    chk_low_route: assert property (
        (ctrl.priority_levels_enable && |(src_pending & ~raw_prio)) |=> irq_low_pend)
        else $error("low priority pending source not routed low");

    chk_high_route: assert property (
        (|(src_pending & eff_high)) |=> irq_high_pend ##0 !$past(irq_low_pend && !levels_enable))
        else $error("high priority pending source not routed high");

    chk_read_back_a: assert property (
        s_read_setup(pirq_pkg::OFF_PRIO_A) |=> prdata == {24'h00_0000, $past(prio_a)} && !pslverr)
        else $error("priority_reg_a read back mismatch");

    chk_ctrl_bit: assert property (
        (psel && penable && pwrite && paddr == pirq_pkg::OFF_CTRL)
        |=> ctrl.priority_levels_enable == $past(pwdata[7]) ##1 levels_enable == ctrl.priority_levels_enable)
        else $error("priority_levels_enable not written from bit 7");

    chk_reset_ones: assert property (
        $rose(presetn) |-> prio_b == 8'h00CF)
        else $error("priority_reg_b did not reset to ones");

    chk_unmapped_err: assert property (
        (psel && !penable && pirq_pkg::pirq_decode(paddr) == pirq_pkg::IDX_NONE) |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access did not report an error");

    sequence s_write_ctrl;
        psel && penable && pwrite && paddr == pirq_pkg::OFF_CTRL;
    endsequence

    chk_write_ctrl_gaps: assert property (
        s_write_ctrl |=> ctrl.unused == 7'h00 && ctrl.priority_levels_enable == $past(pwdata[7]))
        else $error("control register low bits not zero after write");

    chk_read_back_b: assert property (
        s_read_setup(pirq_pkg::OFF_PRIO_B) |=> prdata == {24'h00_0000, $past(prio_b)} && !pslverr)
        else $error("priority_reg_b read back mismatch");

    chk_read_ctrl: assert property (
        s_read_setup(pirq_pkg::OFF_CTRL) |=> prdata == {24'h00_0000, $past(ctrl)} && !pslverr)
        else $error("control register read back mismatch");

    chk_read_map: assert property (
        s_read_setup(pirq_pkg::OFF_LEVEL_MAP) |=> prdata == {18'h0_0000, $past(src_high_level)})
        else $error("level map read back mismatch");

    chk_read_pend: assert property (
        s_read_setup(pirq_pkg::OFF_PENDING) |=> prdata[31:30] == 2'b00 && prdata[15:14] == 2'b00)
        else $error("pending read shows bits outside the source fields");

    chk_pend_split: assert property (
        s_read_setup(pirq_pkg::OFF_PENDING) |=> (prdata[29:16] & prdata[13:0]) == 14'h0000)
        else $error("a source reads as routed to both levels");

    chk_map_ro: assert property (
        (psel && penable && pwrite && paddr == pirq_pkg::OFF_LEVEL_MAP) |=> $stable(prio_a) && $stable(prio_b))
        else $error("write to level map changed a priority register");

    chk_pend_ro: assert property (
        (psel && penable && pwrite && paddr == pirq_pkg::OFF_PENDING) |=> $stable(ctrl) && $stable(prio_b))
        else $error("write to pending view changed a register");

    chk_a_hold: assert property (
        !(psel && penable && pwrite && paddr == pirq_pkg::OFF_PRIO_A) |=> $stable(prio_a))
        else $error("priority_reg_a changed without a write");

    chk_b_hold: assert property (
        !(psel && penable && pwrite && paddr == pirq_pkg::OFF_PRIO_B) |=> $stable(prio_b))
        else $error("priority_reg_b changed without a write");

    chk_ctrl_hold: assert property (
        !(psel && penable && pwrite && paddr == pirq_pkg::OFF_CTRL) |=> $stable(ctrl))
        else $error("control register changed without a write");

    chk_b_gap_zero: assert property (
        prio_b.unused == 2'b00)
        else $error("priority_reg_b bits 5-4 hold a value");

    chk_ctrl_low_zero: assert property (
        ctrl.unused == 7'h00)
        else $error("control register low bits hold a value");

    chk_pready_high: assert property (
        pready)
        else $error("ready dropped");

    chk_enable_copy: assert property (
        1'b1 |=> levels_enable == $past(ctrl.priority_levels_enable))
        else $error("levels enable output does not follow control bit");

    chk_high_irq_def: assert property (
        1'b1 |=> irq_high_pend == |($past(src_pending) & $past(eff_high)))
        else $error("high pending output does not match routing");

    chk_low_irq_def: assert property (
        1'b1 |=> irq_low_pend == |($past(src_pending) & ~$past(eff_high)))
        else $error("low pending output does not match routing");

    chk_pend_vec: assert property (
        1'b1 |=> pend_high_vec == ($past(src_pending) & $past(eff_high)))
        else $error("high routed vector does not match routing");

    chk_pend_disjoint: assert property (
        (pend_high_vec & pend_low_vec) == 14'h0000)
        else $error("a source routed to both levels");

    chk_no_pend_quiet: assert property (
        src_pending == 14'h0000 |=> !irq_high_pend && !irq_low_pend)
        else $error("pending output raised with nothing pending");

    chk_map_src_a: assert property (
        raw_prio[7:0] == {prio_a.parallel_port_prio, prio_a.adc_done_prio, prio_a.serial_rx_prio,
                          prio_a.serial_tx_prio, prio_a.sync_serial_prio, prio_a.capcmp1_prio,
                          prio_a.timer2_match_prio, prio_a.timer1_ovf_prio})
        else $error("reg a bits not mapped to their sources");

    chk_map_src_b: assert property (
        raw_prio[13:8] == {prio_b.osc_fail_prio, prio_b.comparator_prio, prio_b.bus_collision_prio,
                           prio_b.volt_detect_prio, prio_b.timer3_ovf_prio, prio_b.capcmp2_prio})
        else $error("reg b bits not mapped to their sources");

    chk_bad_write_ignored: assert property (
        (psel && penable && pwrite && pirq_pkg::pirq_decode(paddr) == pirq_pkg::IDX_NONE)
        |=> $stable(prio_a) && $stable(prio_b) && $stable(ctrl))
        else $error("unmapped write changed a register");

    chk_reset_a: assert property (
        $rose(presetn) |-> prio_a == (pirq_pkg::PRIO_RESET & PRIO_A_MASK))
        else $error("priority_reg_a did not reset to ones");

    chk_reset_ctrl: assert property (
        $rose(presetn) |-> ctrl == pirq_pkg::CTRL_RESET && !levels_enable)
        else $error("control register not clear after reset");

    chk_reset_map: assert property (
        $rose(presetn) |-> src_high_level == 14'h3FFF)
        else $error("level map not single level after reset");

    chk_mapped_ok: assert property (
        (psel && !penable && pirq_pkg::pirq_decode(paddr) != pirq_pkg::IDX_NONE) |=> !pslverr)
        else $error("mapped access reported an error");

    chk_write_rd_zero: assert property (
        (psel && !penable && pwrite) |=> prdata == 32'h0000_0000)
        else $error("write transfer left read data on the bus");

endmodule // pirq_prio_regs

// >>> testbench/testbench.sv
// Self-checking bench for the peripheral interrupt priority registers
`timescale 1ns/10ps
module testbench;
    typedef struct {
        logic [31:0] data;
        logic [31:0] data_r;
        logic        err;
        logic        port;
        logic [13:0] lvl;
        logic        hi;
        logic        lo;
        logic        en;
    } pirq_tb_note_s;

    localparam logic [11:0] RA = pirq_pkg::OFF_PRIO_A;
    localparam logic [11:0] RB = pirq_pkg::OFF_PRIO_B;
    localparam logic [11:0] RC = pirq_pkg::OFF_CTRL;
    localparam logic [11:0] RM = pirq_pkg::OFF_LEVEL_MAP;
    localparam logic [11:0] RP = pirq_pkg::OFF_PENDING;

    logic          pclk;
    logic          presetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [11:0]   paddr;
    logic [31:0]   pwdata;
    logic [13:0]   src_pending;
    logic          pready;
    logic [31:0]   prdata;
    logic [31:0]   prdata_r;
    logic          pslverr;
    logic          pslverr_r;
    logic [13:0]   src_high_level;
    logic          levels_enable;
    logic          irq_high_pend;
    logic          irq_low_pend;
    logic [7:0]    ra;
    logic [7:0]    rb;
    logic          en;
    integer        num_errors;
    integer        tests_run;
    integer        seed;
    integer        i;
    pirq_tb_note_s notes[$];
    pirq_tb_note_s cur;

    pirq_prio_regs #(.REDUCED_PINS(1'b0)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .src_pending(src_pending), .src_high_level(src_high_level), .levels_enable(levels_enable),
        .irq_high_pend(irq_high_pend), .irq_low_pend(irq_low_pend));
    // Reduced variant on the same bus, read data only
    pirq_prio_regs #(.REDUCED_PINS(1'b1)) dut_r (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(), .prdata(prdata_r), .pslverr(pslverr_r),
        .src_pending(src_pending), .src_high_level(), .levels_enable(), .irq_high_pend(), .irq_low_pend());

    always #5 pclk = ~pclk;

    function automatic logic [13:0] lvl_of(input logic [7:0] pa);
        lvl_of = en ? {rb[7], rb[6], rb[3:0], pa} : 14'h3FFF;
    endfunction

    function automatic logic [31:0] model(input logic [11:0] a, input logic [7:0] pa);
        logic [13:0] l;
        l = lvl_of(pa);
        case (a)
            RA:      model = {24'h00_0000, pa};
            RB:      model = {24'h00_0000, rb};
            RC:      model = {24'h00_0000, en, 7'h00};
            RM:      model = {18'h0_0000, l};
            RP:      model = {2'h0, src_pending & ~l, 2'h0, src_pending & l};
            default: model = 32'h0000_0000;
        endcase
    endfunction

    task automatic give_verdict();
        $display("Comparisons %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_read(input pirq_tb_note_s n);
        cmp(prdata, n.data, "read data");
        cmp(prdata_r, n.data_r, "reduced read data");
        cmp({31'h0000_0000, pslverr}, {31'h0000_0000, n.err}, "error response");
    endtask

    task automatic chk_route(input pirq_tb_note_s n);
        cmp({18'h0_0000, src_high_level}, {18'h0_0000, n.lvl}, "level map port");
        cmp({29'h0000_0000, irq_high_pend, irq_low_pend, levels_enable}, {29'h0000_0000, n.hi, n.lo, n.en}, "routing");
    endtask

    // Setup now, access next cycle, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        pirq_tb_note_s n;
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr) begin
            n.data = model(a, ra);
            n.data_r = model(a, ra & 8'h7F);
            n.err = !(a inside {RA, RB, RC, RM, RP});
            n.port = (a == RP);
            n.lvl = lvl_of(ra);
            n.hi = |(src_pending & n.lvl);
            n.lo = |(src_pending & ~n.lvl);
            n.en = en;
            notes.push_back(n);
        end
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k = k + 1;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            num_errors = num_errors + 1;
            $display("ERROR t=%0t no ready", $time);
            give_verdict();
        end
        if (wr && a == RA) ra = d[7:0];
        if (wr && a == RB) rb = d[7:0] & 8'hCF;
        if (wr && a == RC) en = d[7];
    endtask

    task automatic idle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        ra = 8'hFF;
        rb = 8'hCF;
        en = 1'b0;
        @(posedge pclk);
    endtask

    // Result watcher: oldest note against each completed read
    always @(posedge pclk) begin
        if (presetn === 1'b1 && psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            if (notes.size() == 0) begin
                cmp(32'h0000_0000, 32'h0000_0001, "unexpected read");
            end else begin
                cur = notes.pop_front();
                chk_read(cur);
                if (cur.port) chk_route(cur);
            end
        end
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, src_pending} = '0;
        seed = 32'hb5d0;
        num_errors = 0;
        tests_run = 0;
        @(posedge pclk);
        do_reset();
        for (i = 0; i < 6; i++) apb(1'b0, i < 5 ? 12'(4 * i) : 12'hFFC, 32'h0000_0000);
        apb(1'b1, RB, 32'hFFFF_FF30);
        apb(1'b0, RB, 32'h0000_0000);
        apb(1'b1, RA, 32'h0000_00FF);
        apb(1'b1, RM, 32'h0000_0000);
        apb(1'b1, 12'h014, 32'h0000_00AA);
        apb(1'b0, RA, 32'h0000_0000);
        for (i = 0; i < 8; i++) begin
            apb(1'b1, RA, $random(seed));
            apb(1'b1, RB, $random(seed));
            apb(1'b0, RA, 32'h0000_0000);
            apb(1'b0, RB, 32'h0000_0000);
        end
        idle(3);
        apb(1'b0, RP, 32'h0000_0000);
        apb(1'b1, RC, 32'h0000_0080);
        for (i = 0; i < 15; i++) begin
            src_pending <= i < 14 ? 14'h0001 << i : 14'($random(seed));
            apb(1'b1, RA, $random(seed));
            apb(1'b1, RB, $random(seed));
            idle(3);
            apb(1'b0, RP, 32'h0000_0000);
            apb(1'b0, RM, 32'h0000_0000);
            apb(1'b0, RC, 32'h0000_0000);
        end
        src_pending <= 14'h3FFF;
        apb(1'b1, RC, 32'h0000_007F);
        idle(3);
        apb(1'b0, RP, 32'h0000_0000);
        apb(1'b0, RA, 32'h0000_0000);
        idle(1);
        do_reset();
        apb(1'b0, RA, 32'h0000_0000);
        apb(1'b0, RB, 32'h0000_0000);
        apb(1'b0, RC, 32'h0000_0000);
        idle(2);
        cmp(notes.size(), 32'h0000_0000, "reads left unanswered");
        give_verdict();
    end
endmodule // testbench
